// ### logic/ifel_interrupt_flag_enable_logic.sv
`timescale 1ns/1ns
module ifel_interrupt_flag_enable_logic (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset,
    // host bus
    input  wire logic       chip_select,
    input  wire logic       chip_select_n,
    input  wire logic [3:0] reg_select,
    input  wire logic       read_not_write,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    // peripheral control lines
    input  wire logic       port_a_edge_input,
    input  wire logic       port_a_control_line,
    input  wire logic       port_b_edge_input,
    input  wire logic       port_b_control_line,
    // mode settings from the control registers
    input  wire logic [7:0] peripheral_line_control,
    input  wire logic [7:0] auxiliary_function_control,
    // events from timers and shifter
    input  wire logic       timer1_timeout,
    input  wire logic       timer2_timeout,
    input  wire logic       shift_done,
    // open drain interrupt request
    output logic            irq_request_n,
    output logic            irq_request_oe
);
    localparam int N = ifel_pkg::NFLAG;

    ifel_flag_if #(.N(N)) fl ();

    logic       access;
    logic       rd;
    logic       wr;
    logic       pa_edge_ev;
    logic       pa_ctl_ev;
    logic       pb_edge_ev;
    logic       pb_ctl_ev;
    logic       shift_on;
    logic       pa_ctl_in;
    logic       pb_ctl_in;
    logic       pending;
    logic [N-1:0] set_v;
    logic [N-1:0] clr_v;
    logic [N-1:0] enable_q;
    logic [N-1:0] enable_d;
    logic [7:0] data_q;
    logic [7:0] data_d;

    function automatic logic hit(input logic [3:0] sel,
                                 input logic [3:0] addr);
        hit = (sel == addr);
    endfunction

    // ************************************************
    // edge detectors on the four control lines
    // ************************************************
    ifel_edge_sync u_pa_edge (
        .mclk       (mclk),
        .reset      (reset),
        .line_in    (port_a_edge_input),
        .rising_sel (peripheral_line_control[ifel_pkg::LC_PA_EDGE_RISE]),
        .edge_pulse (pa_edge_ev)
    );
    ifel_edge_sync u_pa_ctl (
        .mclk       (mclk),
        .reset      (reset),
        .line_in    (port_a_control_line),
        .rising_sel (peripheral_line_control[ifel_pkg::LC_PA_CTL_RISE]),
        .edge_pulse (pa_ctl_ev)
    );
    ifel_edge_sync u_pb_edge (
        .mclk       (mclk),
        .reset      (reset),
        .line_in    (port_b_edge_input),
        .rising_sel (peripheral_line_control[ifel_pkg::LC_PB_EDGE_RISE]),
        .edge_pulse (pb_edge_ev)
    );
    ifel_edge_sync u_pb_ctl (
        .mclk       (mclk),
        .reset      (reset),
        .line_in    (port_b_control_line),
        .rising_sel (peripheral_line_control[ifel_pkg::LC_PB_CTL_RISE]),
        .edge_pulse (pb_ctl_ev)
    );

    ifel_flag_bank #(.N(N)) u_bank (
        .mclk  (mclk),
        .reset (reset),
        .fl    (fl)
    );

    // ************************************************
    // decode and flag set/clear
    // ************************************************
    assign access = chip_select & ~chip_select_n;
    assign rd     = access & read_not_write;
    assign wr     = access & ~read_not_write;
    assign shift_on = auxiliary_function_control[ifel_pkg::AFC_SHIFT_MSB:
                      ifel_pkg::AFC_SHIFT_LSB] != ifel_pkg::SHIFT_OFF;
    // output modes drive the line, so its edges raise nothing
    assign pa_ctl_in = ~peripheral_line_control[ifel_pkg::LC_PA_OUT];
    // serial port owns the b control line while shifting
    assign pb_ctl_in = ~peripheral_line_control[ifel_pkg::LC_PB_OUT]
                       & ~shift_on;

    always_comb begin
        set_v = '0;
        clr_v = '0;
        set_v[ifel_pkg::FLG_PA_CTL]  = pa_ctl_ev & pa_ctl_in;   // [RQ3]
        set_v[ifel_pkg::FLG_PA_EDGE] = pa_edge_ev;              // [RQ4]
        set_v[ifel_pkg::FLG_SHIFT]   = shift_done & shift_on;   // [RQ5]
        set_v[ifel_pkg::FLG_PB_CTL]  = pb_ctl_ev & pb_ctl_in;   // [RQ6]
        set_v[ifel_pkg::FLG_PB_EDGE] = pb_edge_ev;              // [RQ7]
        set_v[ifel_pkg::FLG_TMR2]    = timer2_timeout;          // [RQ8]
        set_v[ifel_pkg::FLG_TMR1]    = timer1_timeout;          // [RQ9]
        if (access && hit(reg_select, ifel_pkg::ADDR_PORT_A)) begin
            clr_v[ifel_pkg::FLG_PA_CTL] =                       // [RQ3]
                ~(pa_ctl_in
                  & peripheral_line_control[ifel_pkg::LC_PA_IND]); // [RQ16]
            clr_v[ifel_pkg::FLG_PA_EDGE] = 1'b1;                // [RQ4]
        end
        if (access && hit(reg_select, ifel_pkg::ADDR_PORT_B)) begin
            clr_v[ifel_pkg::FLG_PB_CTL] =                       // [RQ6]
                ~(pb_ctl_in
                  & peripheral_line_control[ifel_pkg::LC_PB_IND]); // [RQ16]
            clr_v[ifel_pkg::FLG_PB_EDGE] = 1'b1;                // [RQ7]
        end
        // disabled shifter holds its flag at zero
        if ((access && hit(reg_select, ifel_pkg::ADDR_SHIFT)) || !shift_on)
            clr_v[ifel_pkg::FLG_SHIFT] = 1'b1;                  // [RQ5]
        if ((rd && hit(reg_select, ifel_pkg::ADDR_TMR2_LOW))
            || (wr && hit(reg_select, ifel_pkg::ADDR_TMR2_HIGH)))
            clr_v[ifel_pkg::FLG_TMR2] = 1'b1;                   // [RQ8]
        if ((rd && hit(reg_select, ifel_pkg::ADDR_TMR1_LOW))
            || (wr && hit(reg_select, ifel_pkg::ADDR_TMR1_LATH)))
            clr_v[ifel_pkg::FLG_TMR1] = 1'b1;                   // [RQ9]
        // bit 7 of the data is simply not looked at
        if (wr && hit(reg_select, ifel_pkg::ADDR_FLAG))
            clr_v = clr_v | data_in[N-1:0];             // [RQ10] [RQ11]
    end

    assign fl.set = set_v;
    assign fl.clr = clr_v;

    // ************************************************
    // enable register, set/clear write format
    // ************************************************
    always_comb begin
        enable_d = enable_q;
        if (wr && hit(reg_select, ifel_pkg::ADDR_ENABLE)) begin
            if (data_in[ifel_pkg::BIT_TOP])
                enable_d = enable_q | data_in[N-1:0];           // [RQ14]
            else
                enable_d = enable_q & ~data_in[N-1:0];          // [RQ13]
        end
    end

    always_ff @(posedge mclk) begin
        if (reset)
            enable_q <= ifel_pkg::ENABLE_RST;                   // [RQ18]
        else
            enable_q <= enable_d;
    end

    // ************************************************
    // request and read back
    // ************************************************
    assign pending = |(fl.flags & enable_q);                    // [RQ12]

    always_comb begin
        data_d = data_q;
        if (rd && hit(reg_select, ifel_pkg::ADDR_FLAG))
            data_d = {pending, fl.flags};                       // [RQ2] [RQ10]
        else if (rd && hit(reg_select, ifel_pkg::ADDR_ENABLE))
            data_d = {1'b0, enable_q};                          // [RQ15]
    end

    always_ff @(posedge mclk) begin
        if (reset)
            data_q <= ifel_pkg::DATA_RST;
        else
            data_q <= data_d;
    end

    // other addresses belong to neighbouring blocks, so stay off the bus
    assign data_oe  = rd && (hit(reg_select, ifel_pkg::ADDR_FLAG)
                             || hit(reg_select, ifel_pkg::ADDR_ENABLE));
    assign data_out = data_q;

    // open drain: only ever pulls low, shared with other devices
    assign irq_request_n  = 1'b0;
    assign irq_request_oe = pending;                            // [RQ1]
endmodule

// ### logic/ifel_pkg.sv
// Functional notes
// RQ1: irq pin pulled low when enabled flag set
// RQ2: status top bit: OR of flag AND enable
// RQ3: flag 0: a-control edge sets, port a clears
// RQ4: flag 1: a-edge input sets, port a clears
// RQ5: flag 2: eight shifts set, shifter access clears
// RQ6: flag 3: b-control edge sets, port b clears
// RQ7: flag 4: b-edge input sets, port b clears
// RQ8: flag 5 timer two; low read/high write clear
// RQ9: flag 6 timer one; low read/latch write clear
// RQ10: status readable; writing one clears that flag
// RQ11: status bit 7 not stored; write ignored
// RQ12: one enable bit per flag, same position
// RQ13: enable write, bit7 zero clears selected bits
// RQ14: enable write, bit7 one sets selected bits
// RQ15: enable read returns bits, bit 7 zero
// RQ16: independent mode: port access keeps flag
// RQ17: edge select zero falling, one rising
// RQ18: reset clears flags and enables
// RQ19: set beats clear in same cycle
package ifel_pkg;
    localparam int NFLAG = 7;

    // ************************************************
    // register addresses
    // ************************************************
    localparam logic [3:0] ADDR_PORT_B     = 4'h0;
    localparam logic [3:0] ADDR_PORT_A     = 4'h1;
    localparam logic [3:0] ADDR_TMR1_LOW   = 4'h4;
    localparam logic [3:0] ADDR_TMR1_LATH  = 4'h7;
    localparam logic [3:0] ADDR_TMR2_LOW   = 4'h8;
    localparam logic [3:0] ADDR_TMR2_HIGH  = 4'h9;
    localparam logic [3:0] ADDR_SHIFT      = 4'hA;
    localparam logic [3:0] ADDR_FLAG       = 4'hD;
    localparam logic [3:0] ADDR_ENABLE     = 4'hE;

    // ************************************************
    // flag positions
    // ************************************************
    localparam int FLG_PA_CTL  = 0;
    localparam int FLG_PA_EDGE = 1;
    localparam int FLG_SHIFT   = 2;
    localparam int FLG_PB_CTL  = 3;
    localparam int FLG_PB_EDGE = 4;
    localparam int FLG_TMR2    = 5;
    localparam int FLG_TMR1    = 6;
    localparam int BIT_TOP     = 7;

    // ************************************************
    // peripheral and auxiliary control fields
    // ************************************************
    localparam int LC_PA_EDGE_RISE = 0;
    localparam int LC_PA_IND       = 1;
    localparam int LC_PA_CTL_RISE  = 2;
    localparam int LC_PA_OUT       = 3;
    localparam int LC_PB_EDGE_RISE = 4;
    localparam int LC_PB_IND       = 5;
    localparam int LC_PB_CTL_RISE  = 6;
    localparam int LC_PB_OUT       = 7;
    localparam int AFC_SHIFT_LSB   = 2;
    localparam int AFC_SHIFT_MSB   = 4;
    localparam logic [2:0] SHIFT_OFF = 3'h0;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [6:0] FLAG_RST   = 7'h00;
    localparam logic [6:0] ENABLE_RST = 7'h00;
    localparam logic [7:0] DATA_RST   = 8'h00;
endpackage

// ### logic/ifel_flag_if.sv
`timescale 1ns/1ns
interface ifel_flag_if #(
    parameter int N = 7
);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] flags;

    modport bank (
        input  set,
        input  clr,
        output flags
    );
    modport ctrl (
        output set,
        output clr,
        input  flags
    );
endinterface

// ### logic/ifel_edge_sync.sv
`timescale 1ns/1ns
module ifel_edge_sync (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // line and edge choice
    input  wire logic line_in,
    input  wire logic rising_sel,
    // detected edge
    output logic      edge_pulse
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       stable_q;
    logic       stable_d;
    logic       pulse_q;
    logic       pulse_d;

    // ************************************************
    // three stage sync, change counts when 2 and 3 agree
    // ************************************************
    always_comb begin
        sync_d   = {sync_q[1:0], line_in};
        stable_d = stable_q;
        pulse_d  = 1'b0;
        if (sync_q[1] == sync_q[2] && sync_q[2] != stable_q) begin
            stable_d = sync_q[2];
            pulse_d  = (sync_q[2] == rising_sel);  // [RQ17]
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sync_q   <= 3'h0;
            stable_q <= 1'b0;
            pulse_q  <= 1'b0;
        end else begin
            sync_q   <= sync_d;
            stable_q <= stable_d;
            pulse_q  <= pulse_d;
        end
    end

    assign edge_pulse = pulse_q;
endmodule

// ### logic/ifel_flag_bank.sv
`timescale 1ns/1ns
module ifel_flag_bank #(
    parameter int N = 7
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // set, clear and state
    ifel_flag_if.bank fl
);
    logic [N-1:0] flag_q;
    logic [N-1:0] flag_d;

    // ************************************************
    // one latch per flag
    // ************************************************
    generate
        for (genvar i = 0; i < N; i++) begin : g_flag
            always_comb begin
                flag_d[i] = flag_q[i];
                if (fl.clr[i])
                    flag_d[i] = 1'b0;
                if (fl.set[i])
                    flag_d[i] = 1'b1;  // [RQ19]
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (reset)
            flag_q <= ifel_pkg::FLAG_RST[N-1:0];  // [RQ18]
        else
            flag_q <= flag_d;
    end

    assign fl.flags = flag_q;
endmodule

// ### dv/ifel_host_model.sv
`timescale 1ns/1ns
module ifel_host_model (
    // clock
    input  wire logic       mclk,
    // data bus from the block
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    // request wire
    input  wire logic       irq_request_n,
    input  wire logic       irq_request_oe,
    input  wire logic       other_pull,
    // resolved host side
    output logic      [7:0] host_data,
    output logic            irq_line
);
    // ****
    // bus and request wire
    // ****
    logic [7:0] last_q;

    always_ff @(posedge mclk) begin
        if (data_oe) begin
            last_q <= data_out;
        end
    end
    // released bus shows junk, never a stale copy
    assign host_data = data_oe ? data_out : ~last_q;
    // pull-up; any party may pull low
    assign irq_line = !((irq_request_oe && !irq_request_n)
                        || other_pull);
endmodule

// ### dv/ifel_checker_properties.sv
`timescale 1ns/1ns
module ifel_checker (
    // clock and reset
    input wire logic       mclk,
    input wire logic       reset,
    // host bus
    input wire logic       chip_select,
    input wire logic       chip_select_n,
    input wire logic [3:0] reg_select,
    input wire logic       read_not_write,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    // events
    input wire logic [7:0] auxiliary_function_control,
    input wire logic       timer1_timeout,
    input wire logic       shift_done,
    // request pin
    input wire logic       irq_request_n,
    input wire logic       irq_request_oe
);
    // ****
    // decode and enable shadow
    // ****
    logic       acc;
    logic       rd_fl;
    logic       rd_en;
    logic       en_wr;
    logic [6:0] en_q;
    logic [6:0] en_d;

    assign acc = chip_select && !chip_select_n;
    assign rd_fl = acc && read_not_write && reg_select == ifel_pkg::ADDR_FLAG;
    assign rd_en = acc && read_not_write
                   && reg_select == ifel_pkg::ADDR_ENABLE;
    assign en_wr = acc && !read_not_write
                   && reg_select == ifel_pkg::ADDR_ENABLE;

    always_comb begin
        en_d = en_q;
        if (reset) begin
            en_d = 7'h00;
        end else if (en_wr && data_in[7]) begin
            en_d = en_q | data_in[6:0];
        end else if (en_wr) begin
            en_d = en_q & ~data_in[6:0];
        end
    end
    always_ff @(posedge mclk) begin
        en_q <= en_d;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    property p_pin_low;
        irq_request_n == 1'b0;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("request pin data not low");
    property p_gated;
        irq_request_oe |-> en_q != 7'h00;
    endproperty
    a_gated: assert property (p_gated)
        else $error("request with no enable");
    property p_data_oe;
        data_oe == (rd_fl || rd_en);
    endproperty
    a_data_oe: assert property (p_data_oe)
        else $error("data enable wrong");
    property p_top_bit;
        rd_fl |=> data_out[7] == $past(irq_request_oe);
    endproperty
    a_top_bit: assert property (p_top_bit)
        else $error("status top bit wrong");
    property p_en_read;
        rd_en |=> data_out == {1'b0, $past(en_q)};
    endproperty
    a_en_read: assert property (p_en_read)
        else $error("enable read wrong");
    property p_clr_all;
        en_wr && data_in == 8'h7F |=> !irq_request_oe;
    endproperty
    a_clr_all: assert property (p_clr_all)
        else $error("request after disable");
    property p_t1;
        timer1_timeout && en_q[6] && !en_wr |=> irq_request_oe;
    endproperty
    a_t1: assert property (p_t1)
        else $error("timer event lost");
    property p_shift;
        shift_done && en_q[2] && !en_wr
            && auxiliary_function_control[4:2] != 3'h0 |=> irq_request_oe;
    endproperty
    a_shift: assert property (p_shift)
        else $error("shift event lost");
    property p_reset;
        @(posedge mclk) disable iff (1'b0) reset |=> !irq_request_oe;
    endproperty
    a_reset: assert property (p_reset)
        else $error("request after reset");
endmodule

bind ifel_interrupt_flag_enable_logic ifel_checker u_chk (
    .mclk(mclk), .reset(reset), .chip_select(chip_select),
    .chip_select_n(chip_select_n), .reg_select(reg_select),
    .read_not_write(read_not_write), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe),
    .auxiliary_function_control(auxiliary_function_control),
    .timer1_timeout(timer1_timeout), .shift_done(shift_done),
    .irq_request_n(irq_request_n), .irq_request_oe(irq_request_oe)
);

// ### dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam logic [3:0] FL = ifel_pkg::ADDR_FLAG;
    localparam logic [3:0] EN = ifel_pkg::ADDR_ENABLE;
    logic       mclk, reset, cs, csn, rnw, tm1, tm2, sd, other;
    logic       oe, irq_n, irq_oe, irq_line;
    logic [3:0] ra;
    logic [4:0] ln;
    logic [7:0] din, plc, afc, dout, hd, rdv;
    int         n_mismatch, checks_done;

    ifel_interrupt_flag_enable_logic DUT (
        .mclk(mclk), .reset(reset), .chip_select(cs), .chip_select_n(csn),
        .reg_select(ra), .read_not_write(rnw), .data_in(din),
        .data_out(dout), .data_oe(oe), .port_a_edge_input(ln[1]),
        .port_a_control_line(ln[0]), .port_b_edge_input(ln[4]),
        .port_b_control_line(ln[3]), .peripheral_line_control(plc),
        .auxiliary_function_control(afc), .timer1_timeout(tm1),
        .timer2_timeout(tm2), .shift_done(sd), .irq_request_n(irq_n),
        .irq_request_oe(irq_oe)
    );
    ifel_host_model host (
        .mclk(mclk), .data_out(dout), .data_oe(oe), .irq_request_n(irq_n),
        .irq_request_oe(irq_oe), .other_pull(other), .host_data(hd),
        .irq_line(irq_line)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // ****
    // bus and compare tasks
    // ****
    task chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // held two cycles: read data lags the address by one
    task acc(input logic r, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 cs = 1'b1;
        csn = 1'b0;
        rnw = r;
        ra = a;
        din = d;
        repeat (2) @(posedge mclk);
        #1 rdv = hd;
        cs = 1'b0;
        csn = 1'b1;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        acc(1'b1, a, 8'h00);
        chk(rdv, e);
    endtask
    task pulse(input int k);
        @(posedge mclk);
        #1 {tm1, tm2, sd} = 3'(1 << k);
        @(posedge mclk);
        #1 {tm1, tm2, sd} = 3'h0;
    endtask
    // ****
    // scenarios
    // ****
    task s_reset;
        rd(EN, 8'h00);
        rd(FL, 8'h00);
        chk({7'h00, irq_line}, 8'h01);
    endtask
    task s_enable;
        acc(1'b0, EN, 8'hFF);
        rd(EN, 8'h7F);
        acc(1'b0, EN, 8'h05);
        rd(EN, 8'h7A);
        acc(1'b0, EN, 8'h80);
        rd(EN, 8'h7A);
        acc(1'b0, EN, 8'h85);
        rd(EN, 8'h7F);
    endtask
    task s_events;
        logic [3:0] a[6] = '{4'h4, 4'h7, 4'h8, 4'h9, 4'hA, 4'hA};
        logic [7:0] m[6] = '{8'h40, 8'h40, 8'h20, 8'h20, 8'h04, 8'h04};
        afc = 8'h08;
        for (int i = 0; i < 6; i++) begin
            pulse(2 - i / 2);
            chk({7'h00, irq_line}, 8'h00);
            rd(FL, 8'h80 | m[i]);
            acc(~i[0], a[i], 8'h00);
            rd(FL, 8'h00);
        end
        pulse(2);
        acc(1'b0, 4'h4, 8'h00);
        rd(FL, 8'hC0);
        acc(1'b0, FL, 8'hC0);
        rd(FL, 8'h00);
        pulse(1);
        acc(1'b0, EN, 8'h20);
        rd(FL, 8'h20);
        chk({7'h00, irq_line}, 8'h01);
        acc(1'b0, FL, 8'h20);
        acc(1'b0, EN, 8'hA0);
        afc = 8'h00;
        pulse(0);
        rd(FL, 8'h00);
    endtask
    // clearing read and event on the same edge
    task s_race;
        @(posedge mclk);
        #1 {cs, csn, rnw, tm1} = 4'hB;
        ra = 4'h4;
        @(posedge mclk);
        #1 {cs, csn, tm1} = 3'h2;
        rd(FL, 8'hC0);
        acc(1'b1, 4'h4, 8'h00);
    endtask
    task s_lines;
        int b[4] = '{0, 1, 3, 4};
        plc = 8'h55;
        foreach (b[i]) begin
            ln[b[i]] = 1'b1;
            repeat (8) @(posedge mclk);
            rd(FL, 8'h80 | (8'h01 << b[i]));
            acc(1'b0, b[i] < 2 ? 4'h1 : 4'h0, 8'h00);
            rd(FL, 8'h00);
        end
        plc = 8'h22;
        ln = 5'h00;
        repeat (8) @(posedge mclk);
        rd(FL, 8'h9B);
        acc(1'b0, EN, 8'h7F);
        rd(FL, 8'h1B);
        acc(1'b0, EN, 8'hFF);
        acc(1'b0, 4'h1, 8'h00);
        acc(1'b0, 4'h0, 8'h00);
        rd(FL, 8'h89);
        acc(1'b0, FL, 8'h09);
        rd(FL, 8'h00);
        // output modes: control line edges raise no flag
        plc = 8'hCC;
        ln = 5'h09;
        repeat (8) @(posedge mclk);
        rd(FL, 8'h00);
    endtask
    // reset in mid-run with a request pending
    task s_rerst;
        ln = 5'h00;
        pulse(2);
        chk({7'h00, irq_line}, 8'h00);
        @(posedge mclk);
        #1 reset = 1'b1;
        repeat (4) @(posedge mclk);
        #1 reset = 1'b0;
        s_reset;
    endtask

    task final_report;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        {cs, rnw, tm1, tm2, sd, other} = 6'h00;
        {csn, reset} = 2'h3;
        {ra, din, plc, afc, ln} = '0;
        n_mismatch = 0;
        checks_done = 0;
        repeat (4) @(posedge mclk);
        #1 reset = 1'b0;
        s_reset;
        s_enable;
        s_events;
        s_race;
        s_lines;
        s_rerst;
        final_report;
    end
    // whole run is a few hundred cycles
    initial begin
        #20000;
        n_mismatch++;
        final_report;
    end
endmodule
